/* File: logic/opam_pkg.sv */
package opam_pkg;
  // Programming modes
  typedef enum logic [2:0]
  {
    OPAM_MODE_IDLE   = 3'b001,
    OPAM_MODE_SLAVE  = 3'b010,
    OPAM_MODE_SERIAL = 3'b100
  } opam_mode_type;

  // Slave programming cell addresses
  localparam logic [15:0] ADDR_PROTECTION_FUSE = 16'h0778;
  localparam logic [15:0] ADDR_ANALYSIS_A      = 16'h0758;
  localparam logic [15:0] ADDR_ANALYSIS_B      = 16'h0718;
  // Auto programming addresses
  localparam logic [15:0] ADDR_PULSE_LOW       = 16'h4014;
  localparam logic [15:0] ADDR_PULSE_HIGH      = 16'h4015;
  localparam logic [15:0] AUTO_WINDOW_BASE     = 16'h4000;
  localparam logic [2:0]  AUTO_LAST_CHUNK      = 3'h3;
  localparam logic [13:0] AUTO_HALF_LIMIT      = 14'h1fff;
  // Serial windows
  localparam logic [15:0] BANK0_WINDOW_BASE    = 16'ha000;
  localparam logic [15:0] BANK1_WINDOW_BASE    = 16'h8000;
  localparam logic [15:0] BANK_REG_ADDR        = 16'h1ff9;
  localparam logic [7:0]  BANK_REG_RESET       = 8'h00;
  localparam logic [7:0]  BANK_VALUE_LOW       = 8'h00;
  localparam logic [7:0]  BANK_VALUE_HIGH      = 8'h80;
  localparam int          BANK_SEL_BIT         = 7;
  // Monitor command codes
  localparam logic [7:0]  CMD_ESCAPE           = 8'h00;
  localparam logic [7:0]  CMD_WRITE_BYTE       = 8'h07;
  localparam logic [7:0]  CMD_MOVE_TO_ADDRESS  = 8'h0a;
  localparam logic [7:0]  CMD_LIMIT            = 8'h1f;
  // Internal OTP offsets (relative to array start)
  localparam logic [15:0] OTP_UPPER_OFFSET     = 16'h6000;
endpackage

/* File: logic/opam_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module opam_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] st1;
  logic [WIDTH-1:0] st2;
  logic [WIDTH-1:0] st3;
  logic [WIDTH-1:0] next_dout;

  // Accept a change only when the two later stages agree
  always_comb
  begin
    next_dout = dout;
    if (st2 == st3)
    begin
      next_dout = st3;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st1  <= '0;
      st2  <= '0;
      st3  <= '0;
      dout <= '0;
    end
    else
    begin
      st1  <= din;
      st2  <= st1;
      st3  <= st2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

/* File: logic/opam_cells.sv */
`timescale 1ns/1ps
`default_nettype none
module opam_cells
#(
  parameter int CELLS = 3
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [CELLS-1:0] program_en,
  output logic      [CELLS-1:0] cell_set
);
  logic [CELLS-1:0] next_cell_set;

  // Cells only ever set; there is no clear path
  generate
    for (genvar i = 0; i < CELLS; i++)
    begin : g_cell
      always_comb
      begin
        next_cell_set[i] = cell_set[i] | program_en[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cell_set <= '0;
    end
    else
    begin
      cell_set <= next_cell_set;
    end
  end
endmodule
`default_nettype wire

/* File: logic/opam_top.sv */
// What this block does
// - Slave mode decodes fuse cell 0778H and analysis cells 0758H, 0718H.
// - Programmed analysis cells stay set forever; analysis features disabled.
// - Auto mode fetches pulse width low byte 4014H, high byte 4015H.
// - Auto mode shows 16K chunks on 4000-7FFFH; port 1 bits pick chunk.
// - Serial bank 0 maps lower 24K onto A000-FFFFH.
// - Serial bank 1 maps upper 32K onto 8000-FFFFH.
// - Bank chosen by MSB of byte register at PROGRAMMING_BANK_SELECT.
// - Only 00H or 80H allowed; other values enter test mode.
// - Monitor: data shifts in, 0A moves to address, 07 writes byte.
// - Bytes below 1FH are commands unless escaped by command 00.
`timescale 1ns/1ps
`default_nettype none
module opam_top
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire opam_pkg::opam_mode_type mode,
  input  wire logic                   slave_wr,
  input  wire logic [15:0]            slave_addr,
  input  wire logic                   auto_active,
  input  wire logic                   auto_fetch_pw,
  input  wire logic                   auto_pw_high,
  input  wire logic [15:0]            auto_otp_addr,
  input  wire logic [7:0]             ext_data,
  input  wire logic                   ext_data_valid,
  input  wire logic                   rx_valid,
  input  wire logic [7:0]             rx_byte,
  input  wire logic [15:0]            window_addr,
  output logic [15:0]                 ext_addr,
  output logic [2:0]                  port1_chunk,
  output logic [15:0]                 pulse_width_value,
  output logic                        protection_fuse_cell,
  output logic                        analysis_disable_cell_a,
  output logic                        analysis_disable_cell_b,
  output logic                        analysis_enable,
  output logic [7:0]                  programming_bank_select,
  output logic                        test_mode,
  output logic [15:0]                 mon_addr,
  output logic [15:0]                 otp_index,
  output logic                        otp_hit,
  output logic                        otp_write,
  output logic [7:0]                  otp_wdata
);
  import opam_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Pin-level mode strap passes the three-stage filter
  logic [2:0] mode_q;
  opam_sync #(.WIDTH(3)) u_mode_sync
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .din     (mode),
    .dout    (mode_q)
  );
  wire logic in_slave  = mode_q == OPAM_MODE_SLAVE;
  wire logic in_serial = mode_q == OPAM_MODE_SERIAL;

  ////////////////////////////////////////////////////////////////////////
  // slave cell decode
  logic [2:0] cell_prog;
  always_comb
  begin
    cell_prog[0] = in_slave && slave_wr && slave_addr == ADDR_PROTECTION_FUSE;
    cell_prog[1] = in_slave && slave_wr && slave_addr == ADDR_ANALYSIS_A;
    cell_prog[2] = in_slave && slave_wr && slave_addr == ADDR_ANALYSIS_B;
  end

  logic [2:0] cells;
  opam_cells #(.CELLS(3)) u_cells
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_sync_n),
    .program_en (cell_prog),
    .cell_set   (cells)
  );
  // Cells model OTP; reset here stands in for power-up of blank parts
  assign protection_fuse_cell    = cells[0];
  assign analysis_disable_cell_a = cells[1];
  assign analysis_disable_cell_b = cells[2];
  assign analysis_enable = ~(cells[1] | cells[2]);

  ////////////////////////////////////////////////////////////////////////
  // Auto programming address and pulse width
  logic [15:0] next_ext_addr;
  logic [2:0]  next_port1_chunk;
  logic [15:0] next_pulse_width;
  logic        pw_pending_high;
  logic        next_pw_pending_high;

  always_comb
  begin
    next_ext_addr        = ext_addr;
    next_port1_chunk     = port1_chunk;
    next_pulse_width     = pulse_width_value;
    next_pw_pending_high = pw_pending_high;
    if (auto_active)
    begin
      if (auto_fetch_pw)
      begin
        next_ext_addr        = auto_pw_high ? ADDR_PULSE_HIGH : ADDR_PULSE_LOW;
        next_port1_chunk     = 3'h0;
        next_pw_pending_high = auto_pw_high;
      end
      else
      begin
        // chunk on port 1, window 4000-7FFFH
        next_port1_chunk = auto_otp_addr[15:14] + 3'h1;
        if (auto_otp_addr[15:14] == AUTO_LAST_CHUNK[1:0]
            && auto_otp_addr[13:0] > AUTO_HALF_LIMIT)
          next_ext_addr = AUTO_WINDOW_BASE | {3'h0, AUTO_HALF_LIMIT[12:0]};
        else
          next_ext_addr = AUTO_WINDOW_BASE | {2'h0, auto_otp_addr[13:0]};
      end
      if (ext_data_valid && auto_fetch_pw)
      begin
        if (pw_pending_high)
          next_pulse_width[15:8] = ext_data;
        else
          next_pulse_width[7:0] = ext_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ext_addr          <= 16'h0000;
      port1_chunk       <= 3'h0;
      pulse_width_value <= 16'h0000;
      pw_pending_high   <= 1'b0;
    end
    else
    begin
      ext_addr          <= next_ext_addr;
      port1_chunk       <= next_port1_chunk;
      pulse_width_value <= next_pulse_width;
      pw_pending_high   <= next_pw_pending_high;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial monitor
  logic [15:0] mon_data;
  logic [15:0] next_mon_data;
  logic [15:0] next_mon_addr;
  logic        escape;
  logic        next_escape;
  logic [7:0]  next_bank;
  logic        next_test_mode;
  logic        next_otp_write;
  logic [7:0]  next_otp_wdata;
  logic        serial_q;

  always_comb
  begin
    next_mon_data  = mon_data;
    next_mon_addr  = mon_addr;
    next_escape    = escape;
    next_bank      = programming_bank_select;
    next_test_mode = test_mode;
    next_otp_write = 1'b0;
    next_otp_wdata = otp_wdata;
    // bank 0 on entering serial mode
    if (in_serial && !serial_q)
    begin
      next_bank      = BANK_REG_RESET;
      next_escape    = 1'b0;
      next_test_mode = 1'b0;
    end
    else if (in_serial && rx_valid)
    begin
      // escaped or large byte is data
      if (escape || rx_byte >= CMD_LIMIT)
      begin
        next_mon_data = {mon_data[7:0], rx_byte};
        next_escape   = 1'b0;
      end
      else
      begin
        case (rx_byte)
          CMD_ESCAPE:          next_escape = 1'b1;
          CMD_MOVE_TO_ADDRESS: next_mon_addr = mon_data;
          CMD_WRITE_BYTE:
          begin
            if (mon_addr == BANK_REG_ADDR)
            begin
              next_bank = mon_data[7:0];
              next_test_mode = mon_data[7:0] != BANK_VALUE_LOW
                               && mon_data[7:0] != BANK_VALUE_HIGH;
            end
            else if (otp_hit)
            begin
              next_otp_write = 1'b1;
              next_otp_wdata = mon_data[7:0];
            end
          end
          default:             next_escape = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      mon_data                <= 16'h0000;
      mon_addr                <= 16'h0000;
      escape                  <= 1'b0;
      programming_bank_select <= BANK_REG_RESET;
      test_mode               <= 1'b0;
      otp_write               <= 1'b0;
      otp_wdata               <= 8'h00;
      serial_q                <= 1'b0;
    end
    else
    begin
      mon_data                <= next_mon_data;
      mon_addr                <= next_mon_addr;
      escape                  <= next_escape;
      programming_bank_select <= next_bank;
      test_mode               <= next_test_mode;
      otp_write               <= next_otp_write;
      otp_wdata               <= next_otp_wdata;
      serial_q                <= in_serial;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Window mapping uses the monitor address, or the window port when idle
  logic [15:0] map_addr;
  logic        bank_hi;
  always_comb
  begin
    map_addr = rx_valid ? mon_addr : window_addr;
    bank_hi   = programming_bank_select[BANK_SEL_BIT];
    otp_hit   = 1'b0;
    otp_index = 16'h0000;
    if (in_serial)
    begin
      if (bank_hi && map_addr >= BANK1_WINDOW_BASE)
      begin
        otp_hit   = 1'b1;
        otp_index = map_addr - BANK1_WINDOW_BASE + OTP_UPPER_OFFSET;
      end
      else if (!bank_hi && map_addr >= BANK0_WINDOW_BASE)
      begin
        otp_hit   = 1'b1;
        otp_index = map_addr - BANK0_WINDOW_BASE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_cells_sticky: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    analysis_disable_cell_b |=> analysis_disable_cell_b)
    else $error("analysis cell b cleared");
  a_cell_a_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    analysis_disable_cell_a |=> analysis_disable_cell_a)
    else $error("analysis cell a lost");
  a_cell_decode: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    cell_prog[0] |=> protection_fuse_cell)
    else $error("fuse cell not programmed");
  a_analysis_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    cell_prog[2] |=> !analysis_enable)
    else $error("analysis still enabled");
  a_pw_address: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    auto_active && auto_fetch_pw && !auto_pw_high |=> ext_addr == 16'h4014)
    else $error("pulse width low address wrong");
  a_auto_window: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    auto_active && !auto_fetch_pw |=> ext_addr[15:14] == 2'b01)
    else $error("auto address outside window");
  a_bank0_map: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    in_serial && !bank_hi && map_addr == 16'ha000 |-> otp_hit && otp_index == 16'h0000)
    else $error("bank 0 mapping wrong");
  a_bank1_map: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    in_serial && bank_hi && map_addr == 16'h8000 |-> otp_hit && otp_index == 16'h6000)
    else $error("bank 1 mapping wrong");
  a_bank_write: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    serial_q && in_serial && rx_valid && !escape && rx_byte == 8'h07
    && mon_addr == 16'h1ff9 |=> programming_bank_select == $past(mon_data[7:0]))
    else $error("bank register not written");
  a_bad_value: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    test_mode |-> programming_bank_select != 8'h00
    && programming_bank_select != 8'h80)
    else $error("test mode with legal value");
  a_escape_data: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    serial_q && in_serial && rx_valid && escape |=> mon_data[7:0] == $past(rx_byte))
    else $error("escaped byte not taken as data");
  a_move_addr: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    serial_q && in_serial && rx_valid && !escape && rx_byte == 8'h0a
    |=> mon_addr == $past(mon_data))
    else $error("address move failed");
  a_enter_bank0: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    $rose(serial_q) |-> programming_bank_select == 8'h00)
    else $error("bank not reset on entry");

  c_bank1: cover property (@(posedge clk_sys) programming_bank_select == 8'h80);
  c_escape: cover property (@(posedge clk_sys) escape && rx_valid);
  c_otp_write: cover property (@(posedge clk_sys) otp_write);
  c_fuse: cover property (@(posedge clk_sys) protection_fuse_cell);
endmodule
`default_nettype wire

/* File: verif/opam_image_model.sv */
`timescale 1ns/1ps
`default_nettype none
module opam_image_model
#(
  parameter logic [7:0] PW_LOW_BYTE  = 8'h3c,
  parameter logic [7:0] PW_HIGH_BYTE = 8'hb2
)
(
  input  wire logic        clk_sys,
  input  wire logic        fetch,
  input  wire logic        slow,
  input  wire logic [15:0] ext_addr,
  output logic      [7:0]  ext_data,
  output logic             ext_data_valid
);
  logic [15:0] served;
  logic [2:0]  wait_cnt;

  initial
  begin
    served         = 16'h0000;
    wait_cnt       = 3'h0;
    ext_data       = 8'h00;
    ext_data_valid = 1'b0;
  end

  always @(posedge clk_sys)
  begin
    ext_data_valid <= 1'b0;
    // Idle lane toggles so a stale byte is never mistaken for data
    ext_data       <= ~ext_data;
    if (!fetch || ext_addr == served)
      wait_cnt <= 3'h0;
    else if (wait_cnt == (slow ? 3'h4 : 3'h1))
    begin
      ext_data       <= ext_addr[0] ? PW_HIGH_BYTE : PW_LOW_BYTE;
      ext_data_valid <= 1'b1;
      served         <= ext_addr;
      wait_cnt       <= 3'h0;
    end
    else
      wait_cnt <= wait_cnt + 3'h1;
  end
endmodule
`default_nettype wire

/* File: verif/opam_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module opam_top_tb;
  import opam_pkg::*;
  typedef struct packed {logic [3:0] sel; logic [15:0] exp;} opam_note_type;
  localparam logic [7:0] PW_LO = 8'h3c;
  localparam logic [7:0] PW_HI = 8'hb2;

  logic          clk_sys, rst_n, slave_wr, auto_active, auto_fetch_pw, auto_pw_high;
  opam_mode_type mode;
  logic [15:0]   slave_addr, auto_otp_addr, window_addr, ext_addr, pulse_width_value;
  logic [15:0]   mon_addr, otp_index, a, w;
  logic [7:0]    ext_data, rx_byte, programming_bank_select, otp_wdata, wr_data, d;
  logic          ext_data_valid, rx_valid, protection_fuse_cell, analysis_disable_cell_a;
  logic          analysis_disable_cell_b, analysis_enable, test_mode, otp_hit, otp_write;
  logic          wr_seen, slow;
  logic [2:0]    port1_chunk;
  opam_note_type notes[$];
  opam_note_type note;
  int            err_count  = 0;
  int            n_compared = 0;
  int            seed       = 88;
  int            cycles     = 0;

  opam_top u_opam_top (.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode), .slave_wr(slave_wr),
    .slave_addr(slave_addr), .auto_active(auto_active), .auto_fetch_pw(auto_fetch_pw),
    .auto_pw_high(auto_pw_high), .auto_otp_addr(auto_otp_addr), .ext_data(ext_data),
    .ext_data_valid(ext_data_valid), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .window_addr(window_addr), .ext_addr(ext_addr), .port1_chunk(port1_chunk),
    .pulse_width_value(pulse_width_value), .protection_fuse_cell(protection_fuse_cell),
    .analysis_disable_cell_a(analysis_disable_cell_a),
    .analysis_disable_cell_b(analysis_disable_cell_b), .analysis_enable(analysis_enable),
    .programming_bank_select(programming_bank_select), .test_mode(test_mode),
    .mon_addr(mon_addr), .otp_index(otp_index), .otp_hit(otp_hit), .otp_write(otp_write),
    .otp_wdata(otp_wdata));

  opam_image_model #(.PW_LOW_BYTE(PW_LO), .PW_HIGH_BYTE(PW_HI)) u_opam_image_model
    (.clk_sys(clk_sys), .fetch(auto_fetch_pw), .slow(slow), .ext_addr(ext_addr),
     .ext_data(ext_data), .ext_data_valid(ext_data_valid));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] observed(input logic [3:0] sel);
    case (sel)
      4'h0: return {8'h00, programming_bank_select};
      4'h1: return {15'h0000, test_mode};
      4'h2: return {12'h000, protection_fuse_cell, analysis_disable_cell_a,
                    analysis_disable_cell_b, analysis_enable};
      4'h3: return ext_addr;
      4'h4: return {13'h0000, port1_chunk};
      4'h5: return pulse_width_value;
      4'h6: return otp_index;
      4'h7: return {15'h0000, otp_hit};
      4'h8: return mon_addr;
      default: return {7'h00, wr_seen, wr_data};
    endcase
  endfunction

  // Results are sampled mid-cycle, well clear of the launching edge
  always @(negedge clk_sys)
  begin
    while (notes.size() > 0)
    begin
      note = notes.pop_front();
      n_compared++;
      if (observed(note.sel) !== note.exp)
      begin
        err_count++;
        $display("[ERR] %0t sel %0h got %h exp %h", $time, note.sel, observed(note.sel),
                 note.exp);
      end
    end
  end

  always @(posedge clk_sys)
  begin
    if (otp_write === 1'b1)
    begin
      wr_seen <= 1'b1;
      wr_data <= otp_wdata;
    end
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic expect_val(input logic [3:0] sel, input logic [15:0] exp);
    notes.push_back('{sel, exp});
    @(negedge clk_sys);
    @(posedge clk_sys);
  endtask

  task automatic put(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_byte  <= b;
  endtask

  task automatic data_byte(input logic [7:0] b);
    // escape small data; 1F itself is plain data
    if (b < 8'h1f)
      put(CMD_ESCAPE);
    put(b);
  endtask

  // Bytes go back to back; the line carries noise once released
  task automatic mon_write(input logic [15:0] addr, input logic [7:0] val);
    data_byte(addr[15:8]);
    data_byte(addr[7:0]);
    put(CMD_MOVE_TO_ADDRESS);
    data_byte(val);
    put(CMD_WRITE_BYTE);
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_byte  <= 8'($random(seed));
    cyc(3);
  endtask

  task automatic slave_hit(input logic [15:0] addr, input logic [3:0] cells);
    @(posedge clk_sys);
    slave_wr   <= 1'b1;
    slave_addr <= addr;
    @(posedge clk_sys);
    slave_wr   <= 1'b0;
    cyc(2);
    expect_val(4'h2, {12'h000, cells});
  endtask

  task automatic map_chk(input logic [15:0] win, input logic hit, input logic [15:0] idx);
    @(posedge clk_sys);
    window_addr <= win;
    cyc(1);
    expect_val(4'h7, {15'h0000, hit});
    if (hit)
      expect_val(4'h6, idx);
  endtask

  task automatic enter(input opam_mode_type m);
    @(posedge clk_sys);
    mode <= m;
    cyc(8);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;  mode = OPAM_MODE_IDLE;  slave_wr = 1'b0;  slave_addr = 16'h0000;
    auto_active = 1'b0;  auto_fetch_pw = 1'b0;  auto_pw_high = 1'b0;  slow = 1'b0;
    auto_otp_addr = 16'h0000;  rx_valid = 1'b0;  rx_byte = 8'h00;  window_addr = 16'h0000;
    wr_seen = 1'b0;  wr_data = 8'h00;
    cyc(12);
    rst_n <= 1'b1;
    cyc(4);
    expect_val(4'h0, {8'h00, BANK_REG_RESET});
    enter(OPAM_MODE_SLAVE);
    slave_hit(16'h0218, 4'h1);
    slave_hit(ADDR_PROTECTION_FUSE, 4'h9);
    slave_hit(ADDR_ANALYSIS_A, 4'hc);
    slave_hit(ADDR_ANALYSIS_B, 4'he);
    enter(OPAM_MODE_IDLE);
    slave_hit(16'h0000, 4'he);
    @(posedge clk_sys);
    auto_active   <= 1'b1;
    auto_fetch_pw <= 1'b1;
    cyc(2);
    expect_val(4'h3, ADDR_PULSE_LOW);
    cyc(6);
    expect_val(4'h5, {8'h00, PW_LO});
    auto_pw_high <= 1'b1;
    slow         <= 1'b1;
    cyc(2);
    expect_val(4'h3, ADDR_PULSE_HIGH);
    cyc(10);
    expect_val(4'h5, {PW_HI, PW_LO});
    auto_fetch_pw <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      a = (i < 4) ? (i == 0 ? 16'h0000 : i == 1 ? 16'h3fff : i == 2 ? 16'h4000 : 16'hdfff)
                  : 16'($unsigned($random(seed)) % 32'h0000_e000);
      auto_otp_addr <= a;
      cyc(2);
      expect_val(4'h3, {2'b01, a[13:0]});
      expect_val(4'h4, {13'h0000, 3'(a[15:14]) + 3'h1});
    end
    // Past the last 8K the window keeps to its lower half
    auto_otp_addr <= 16'hf123;
    cyc(2);
    expect_val(4'h3, 16'h5fff);
    auto_active <= 1'b0;
    enter(OPAM_MODE_SERIAL);
    expect_val(4'h0, 16'h0000);
    mon_write(BANK_REG_ADDR, BANK_VALUE_HIGH);
    expect_val(4'h0, {8'h00, BANK_VALUE_HIGH});
    expect_val(4'h1, 16'h0000);
    expect_val(4'h9, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      w = 16'h8000 | 16'($random(seed));
      map_chk(w, 1'b1, OTP_UPPER_OFFSET + (w - BANK1_WINDOW_BASE));
    end
    map_chk(16'h7fff, 1'b0, 16'h0000);
    mon_write(BANK_REG_ADDR, BANK_VALUE_LOW);
    expect_val(4'h0, {8'h00, BANK_VALUE_LOW});
    for (int i = 0; i < 6; i++)
    begin
      w = BANK0_WINDOW_BASE + 16'($unsigned($random(seed)) % 32'h0000_6000);
      map_chk(w, 1'b1, w - BANK0_WINDOW_BASE);
    end
    map_chk(16'h9fff, 1'b0, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      a = BANK0_WINDOW_BASE + 16'($unsigned($random(seed)) % 32'h0000_6000);
      d = (i == 0) ? 8'h05 : 8'($random(seed));
      wr_seen <= 1'b0;
      mon_write(a, d);
      expect_val(4'h8, a);
      expect_val(4'h9, {7'h00, 1'b1, d});
    end
    mon_write(BANK_REG_ADDR, 8'h41);
    expect_val(4'h1, 16'h0001);
    map_chk(BANK0_WINDOW_BASE, 1'b1, 16'h0000);
    mon_write(BANK_REG_ADDR, 8'hc3);
    map_chk(BANK1_WINDOW_BASE, 1'b1, OTP_UPPER_OFFSET);
    enter(OPAM_MODE_IDLE);
    enter(OPAM_MODE_SERIAL);
    expect_val(4'h0, 16'h0000);
    expect_val(4'h1, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
